// *** logic/cpusf_pkg.sv ***
// Package for the status flag and arithmetic datapath block.
// Assumes a single system clock and a plain register port.
package cpusf_pkg;
    // Processor flags bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_I = 2;
    localparam int FLAG_D = 3;
    localparam int FLAG_B = 4;
    localparam int FLAG_T = 5;
    localparam int FLAG_V = 6;
    localparam int FLAG_N = 7;
    // Reset value: only interrupt disable is defined, others zero here
    localparam logic [7:0] FLAGS_RESET = 8'h04;
    // Register map, word addresses
    localparam logic [3:0] REG_FLAGS = 4'h0;
    localparam logic [3:0] REG_ACC = 4'h1;
    localparam logic [3:0] REG_OPER = 4'h2;
    localparam logic [3:0] REG_CMD = 4'h3;
    localparam logic [3:0] REG_RESULT = 4'h4;
    localparam logic [3:0] REG_STACK_PTR = 4'h5;
    localparam logic [3:0] REG_STACK_RD = 4'h6;
    localparam logic [3:0] REG_DIR = 4'h7;
    localparam logic [3:0] REG_SPEED = 4'h8;
    localparam logic [3:0] REG_IRQ = 4'h9;
    localparam logic [3:0] REG_TRAP_VEC = 4'ha;
    // Phi dividers per speed mode
    localparam logic [3:0] DIV_HIGH = 4'h2;
    localparam logic [3:0] DIV_MIDDLE = 4'h8;
    localparam logic [3:0] DIV_LOW = 4'h2;
    localparam logic [1:0] SPEED_RESET = 2'h1;
    // Fixed cycle counts of each operation, in phi cycles
    localparam logic [3:0] CYC_ALU = 4'h2;
    localparam logic [3:0] CYC_PUSH = 4'h3;
    localparam logic [3:0] CYC_TRAP = 4'h7;
    localparam logic [3:0] CYC_PROD = 4'h8;
    // Stack depth as address bits: 16 entries
    localparam int STACK_AW = 4;
    // Operation codes written to the command register
    typedef enum logic [3:0] {
        CMD_ADC = 4'h1, CMD_SUB_BORROW = 4'h2, CMD_CARRY_SET = 4'h3, CMD_CARRY_CLEAR = 4'h4,
        CMD_DEC_SET = 4'h5, CMD_DEC_CLEAR = 4'h6, CMD_PUSH = 4'h7, CMD_POP = 4'h8,
        CMD_PRODUCT = 4'h9, CMD_DIV = 4'ha, CMD_TRAP = 4'hb, CMD_SET_T = 4'hc,
        CMD_CLR_T = 4'hd
    } cpusf_cmd_type;
    // Execution state machine, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001, ST_RUN = 3'b010, ST_DONE = 3'b100
    } cpusf_state_type;
    // Register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cpusf_bus_type;
    // Speed mode codes
    localparam logic [1:0] SPEED_HIGH = 2'h0;
    localparam logic [1:0] SPEED_MIDDLE = 2'h1;
    localparam logic [1:0] SPEED_LOW = 2'h2;
    // Number of interrupt sources
    localparam int IRQ_N = 4;
endpackage

// *** logic/cpusf_stack_mem.sv ***
// Small stack memory used for the flags push and pop.
// Assumes single clock; read data come from a register.
`timescale 1ns/1ps
module cpusf_stack_mem (
    input wire logic clk,
    input wire logic we,
    input wire logic [cpusf_pkg::STACK_AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [cpusf_pkg::STACK_AW-1:0] raddr,
    output logic [7:0] rdata
);
    // Storage words, not reset
    logic [7:0] mem [0:(1<<cpusf_pkg::STACK_AW)-1];

    // Write then registered read
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// *** logic/cpusf_core.sv ***
// Status flags datapath: flags, decimal add/sub, push/pop, trap, phi.
// Assumes synchronous software access through a plain register port.
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module cpusf_core (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic MAIN_OSC_INPUT,
    input wire logic SUB_OSC_INPUT,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [cpusf_pkg::IRQ_N-1:0] IRQ_REQ,
    output logic [7:0] RDATA,
    output logic [7:0] PORT_DIR,
    output logic PHI,
    output logic BUSY
);
    // Bus request bundle
    cpusf_pkg::cpusf_bus_type bus;
    assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    // Architectural state
    logic [7:0] flags_q, flags_d;
    logic [7:0] acc_q, acc_d;
    logic [7:0] oper_q, oper_d;
    logic [7:0] result_q, result_d;
    logic [7:0] dir_q, dir_d;
    logic [1:0] speed_q, speed_d;
    logic [cpusf_pkg::IRQ_N-1:0] irq_en_q, irq_en_d;
    logic [7:0] trap_vec_q, trap_vec_d;
    logic [cpusf_pkg::STACK_AW-1:0] sp_q, sp_d;
    logic [7:0] rdata_q, rdata_d;
    // Execution control
    cpusf_pkg::cpusf_state_type st_q, st_d;
    cpusf_pkg::cpusf_cmd_type cmd_q, cmd_d;
    logic [3:0] cyc_q, cyc_d;
    // Phi generator
    logic [3:0] div_q, div_d;
    logic phi_q, phi_d;
    logic osc_q, osc_d;
    logic osc_edge;
    logic phi_tick;
    logic [3:0] div_ratio;
    // Stack memory port
    logic stk_we;
    logic [cpusf_pkg::STACK_AW-1:0] stk_waddr;
    logic [cpusf_pkg::STACK_AW-1:0] stk_raddr;
    logic [7:0] stk_rdata;
    // Arithmetic results
    logic [8:0] bin_sum;
    logic [4:0] lo_dec;
    logic [8:0] dec_sum;
    logic [15:0] prod;
    logic [7:0] quot;
    logic [7:0] opnd;
    logic carry_out;
    logic pend_any;
    logic [7:0] pend_vec;

    cpusf_stack_mem u_stack (
        .clk(CLK_SYS),
        .we(stk_we),
        .waddr(stk_waddr),
        .wdata(flags_q),
        .raddr(stk_raddr),
        .rdata(stk_rdata)
    );

    // Oscillator select and divide down to phi
    always_comb begin
        unique case (speed_q)
            cpusf_pkg::SPEED_HIGH: div_ratio = cpusf_pkg::DIV_HIGH;
            cpusf_pkg::SPEED_MIDDLE: div_ratio = cpusf_pkg::DIV_MIDDLE;
            default: div_ratio = cpusf_pkg::DIV_LOW;
        endcase
        // Low speed counts the sub oscillator instead
        osc_d = (speed_q == cpusf_pkg::SPEED_LOW) ? SUB_OSC_INPUT : MAIN_OSC_INPUT;
        osc_edge = osc_d & ~osc_q;
        div_d = div_q;
        phi_d = phi_q;
        phi_tick = 1'b0;
        if (osc_edge) begin
            // Half of the ratio high, half low
            if (div_q + 4'h1 >= (div_ratio >> 1)) begin
                div_d = 4'h0;
                phi_d = ~phi_q;
                phi_tick = ~phi_q;
            end else begin
                div_d = div_q + 4'h1;
            end
        end
    end

    // Phi registers
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            div_q <= 4'h0;
            phi_q <= 1'b0;
            osc_q <= 1'b0;
        end else begin
            div_q <= div_d;
            phi_q <= phi_d;
            osc_q <= osc_d;
        end
    end

    // Datapath arithmetic
    always_comb begin
        // Subtract uses the complemented operand
        opnd = (cmd_q == cpusf_pkg::CMD_SUB_BORROW) ? ~oper_q : oper_q;
        bin_sum = {1'b0, acc_q} + {1'b0, opnd} + {8'h00, flags_q[cpusf_pkg::FLAG_C]};
        // Decimal add and subtract correct each nibble
        dec_sum = 9'h000;
        lo_dec = 5'h00;
        if (cmd_q == cpusf_pkg::CMD_ADC) begin
            lo_dec = {1'b0, acc_q[3:0]} + {1'b0, oper_q[3:0]}
                + {4'h0, flags_q[cpusf_pkg::FLAG_C]};
            if (lo_dec > 5'h09) begin
                lo_dec = lo_dec + 5'h06;
            end
            dec_sum = {5'h00, acc_q[7:4]} + {5'h00, oper_q[7:4]} + {8'h00, lo_dec[4]};
            if (dec_sum > 9'h009) begin
                dec_sum = dec_sum + 9'h006;
            end
            dec_sum = {dec_sum[4:0], lo_dec[3:0]};
        end else begin
            lo_dec = {1'b0, acc_q[3:0]} - {1'b0, oper_q[3:0]}
                - {4'h0, ~flags_q[cpusf_pkg::FLAG_C]};
            if (lo_dec[4]) begin
                lo_dec = lo_dec - 5'h06;
            end
            dec_sum = {5'h00, acc_q[7:4]} - {5'h00, oper_q[7:4]} - {8'h00, lo_dec[4]};
            if (dec_sum[8]) begin
                dec_sum = dec_sum - 9'h006;
            end
            // Bit 8 high means no borrow
            dec_sum = {~dec_sum[8], dec_sum[3:0], lo_dec[3:0]};
        end
        carry_out = flags_q[cpusf_pkg::FLAG_D] ? dec_sum[8] : bin_sum[8];
        prod = acc_q * oper_q;
        // Divide by zero yields all ones
        quot = (oper_q == 8'h00) ? 8'hff : acc_q / oper_q;
    end

    // Highest priority pending, enabled interrupt: lowest index wins
    always_comb begin
        pend_any = 1'b0;
        pend_vec = 8'h00;
        for (int i = cpusf_pkg::IRQ_N - 1; i >= 0; i--) begin
            if (IRQ_REQ[i] && irq_en_q[i]) begin
                pend_any = 1'b1;
                pend_vec = 8'(i + 1);
            end
        end
    end

    // Register access, command issue and execution
    always_comb begin
        flags_d = flags_q;
        acc_d = acc_q;
        oper_d = oper_q;
        result_d = result_q;
        dir_d = dir_q;
        speed_d = speed_q;
        irq_en_d = irq_en_q;
        trap_vec_d = trap_vec_q;
        sp_d = sp_q;
        st_d = st_q;
        cmd_d = cmd_q;
        cyc_d = cyc_q;
        stk_we = 1'b0;
        stk_waddr = sp_q;
        stk_raddr = sp_q + 4'(1);
        rdata_d = 8'h00;
        // Reads; direction register reads back zero
        if (bus.rd) begin
            unique case (bus.addr)
                cpusf_pkg::REG_FLAGS: rdata_d = flags_q;
                cpusf_pkg::REG_ACC: rdata_d = acc_q;
                cpusf_pkg::REG_OPER: rdata_d = oper_q;
                cpusf_pkg::REG_CMD: rdata_d = {7'h00, st_q != cpusf_pkg::ST_IDLE};
                cpusf_pkg::REG_RESULT: rdata_d = result_q;
                cpusf_pkg::REG_STACK_PTR: rdata_d = {4'h0, sp_q};
                cpusf_pkg::REG_STACK_RD: rdata_d = stk_rdata;
                cpusf_pkg::REG_DIR: rdata_d = 8'h00;
                cpusf_pkg::REG_SPEED: rdata_d = {6'h00, speed_q};
                cpusf_pkg::REG_IRQ: rdata_d = {4'h0, irq_en_q};
                cpusf_pkg::REG_TRAP_VEC: rdata_d = trap_vec_q;
                default: rdata_d = 8'h00;
            endcase
        end
        // Writes; commands only taken while idle
        if (bus.wr) begin
            unique case (bus.addr)
                cpusf_pkg::REG_ACC: acc_d = bus.wdata;
                cpusf_pkg::REG_OPER: oper_d = bus.wdata;
                cpusf_pkg::REG_STACK_PTR: sp_d = bus.wdata[cpusf_pkg::STACK_AW-1:0];
                cpusf_pkg::REG_DIR: dir_d = bus.wdata;
                cpusf_pkg::REG_SPEED: speed_d = bus.wdata[1:0];
                cpusf_pkg::REG_IRQ: irq_en_d = bus.wdata[cpusf_pkg::IRQ_N-1:0];
                cpusf_pkg::REG_CMD: begin
                    if (st_q == cpusf_pkg::ST_IDLE) begin
                        cmd_d = cpusf_pkg::cpusf_cmd_type'(bus.wdata[3:0]);
                        st_d = cpusf_pkg::ST_RUN;
                        cyc_d = 4'h0;
                    end
                end
                default: begin
                    // Flags and unmapped addresses ignore writes
                end
            endcase
        end
        unique case (st_q)
            cpusf_pkg::ST_IDLE: begin
            end
            cpusf_pkg::ST_RUN: begin
                // Count phi cycles to a fixed total per operation
                if (phi_tick) begin
                    cyc_d = cyc_q + 4'h1;
                end
                if (phi_tick && cyc_q + 4'h1 >= cyc_total(cmd_q)) begin
                    st_d = cpusf_pkg::ST_DONE;
                end
            end
            cpusf_pkg::ST_DONE: begin
                st_d = cpusf_pkg::ST_IDLE;
                unique case (cmd_q)
                    cpusf_pkg::CMD_ADC, cpusf_pkg::CMD_SUB_BORROW: begin
                        if (flags_q[cpusf_pkg::FLAG_D]) begin
                            result_d = dec_sum[7:0];
                            // N, V, Z left as they were
                        end else begin
                            result_d = bin_sum[7:0];
                            flags_d[cpusf_pkg::FLAG_N] = bin_sum[7];
                            flags_d[cpusf_pkg::FLAG_Z] = bin_sum[7:0] == 8'h00;
                            flags_d[cpusf_pkg::FLAG_V] = (acc_q[7] == opnd[7])
                                && (bin_sum[7] != acc_q[7]);
                        end
                        flags_d[cpusf_pkg::FLAG_C] = carry_out;
                        acc_d = result_d;
                    end
                    cpusf_pkg::CMD_CARRY_SET: flags_d[cpusf_pkg::FLAG_C] = 1'b1;
                    cpusf_pkg::CMD_CARRY_CLEAR: flags_d[cpusf_pkg::FLAG_C] = 1'b0;
                    cpusf_pkg::CMD_DEC_SET: flags_d[cpusf_pkg::FLAG_D] = 1'b1;
                    cpusf_pkg::CMD_DEC_CLEAR: flags_d[cpusf_pkg::FLAG_D] = 1'b0;
                    cpusf_pkg::CMD_SET_T: flags_d[cpusf_pkg::FLAG_T] = 1'b1;
                    cpusf_pkg::CMD_CLR_T: flags_d[cpusf_pkg::FLAG_T] = 1'b0;
                    cpusf_pkg::CMD_PUSH: begin
                        // Store at S, then S drops so S+1 holds flags
                        stk_we = 1'b1;
                        sp_d = sp_q - 4'(1);
                    end
                    cpusf_pkg::CMD_POP: begin
                        flags_d = stk_rdata;
                        sp_d = sp_q + 4'(1);
                    end
                    cpusf_pkg::CMD_PRODUCT: begin
                        // Flags untouched, T and D ignored
                        result_d = prod[15:8];
                        acc_d = prod[7:0];
                    end
                    cpusf_pkg::CMD_DIV: begin
                        result_d = acc_q - 8'(quot * oper_q);
                        acc_d = quot;
                    end
                    cpusf_pkg::CMD_TRAP: begin
                        // Trap runs even with interrupts disabled
                        trap_vec_d = pend_any ? pend_vec : 8'h00;
                        flags_d[cpusf_pkg::FLAG_I] = 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
            default: st_d = cpusf_pkg::ST_IDLE;
        endcase
    end

    // Phi cycle totals per operation
    function automatic logic [3:0] cyc_total(input cpusf_pkg::cpusf_cmd_type c);
        unique case (c)
            cpusf_pkg::CMD_PUSH, cpusf_pkg::CMD_POP: cyc_total = cpusf_pkg::CYC_PUSH;
            cpusf_pkg::CMD_PRODUCT, cpusf_pkg::CMD_DIV: cyc_total = cpusf_pkg::CYC_PROD;
            cpusf_pkg::CMD_TRAP: cyc_total = cpusf_pkg::CYC_TRAP;
            default: cyc_total = cpusf_pkg::CYC_ALU;
        endcase
    endfunction

    // State registers
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            flags_q <= cpusf_pkg::FLAGS_RESET;
            acc_q <= 8'h00;
            oper_q <= 8'h00;
            result_q <= 8'h00;
            dir_q <= 8'h00;
            speed_q <= cpusf_pkg::SPEED_RESET;
            irq_en_q <= '0;
            trap_vec_q <= 8'h00;
            sp_q <= '1;
            rdata_q <= 8'h00;
            st_q <= cpusf_pkg::ST_IDLE;
            cmd_q <= cpusf_pkg::CMD_ADC;
            cyc_q <= 4'h0;
        end else begin
            flags_q <= flags_d;
            acc_q <= acc_d;
            oper_q <= oper_d;
            result_q <= result_d;
            dir_q <= dir_d;
            speed_q <= speed_d;
            irq_en_q <= irq_en_d;
            trap_vec_q <= trap_vec_d;
            sp_q <= sp_d;
            rdata_q <= rdata_d;
            st_q <= st_d;
            cmd_q <= cmd_d;
            cyc_q <= cyc_d;
        end
    end

    assign RDATA = rdata_q;
    assign PORT_DIR = dir_q;
    assign PHI = phi_q;
    assign BUSY = st_q != cpusf_pkg::ST_IDLE;
endmodule

// *** verif/cpusf_core_monitor.sv ***
// Checker for the status flag block: port timing relations.
// Assumes binding to cpusf_core, one clock, sync active-low reset.
`timescale 1ns/1ps
module cpusf_core_monitor (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic MAIN_OSC_INPUT,
    input wire logic SUB_OSC_INPUT,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [cpusf_pkg::IRQ_N-1:0] IRQ_REQ,
    input wire logic [7:0] RDATA,
    input wire logic [7:0] PORT_DIR,
    input wire logic PHI,
    input wire logic BUSY
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    logic [3:0] still_q, still_d; // Cycles both oscillators held still
    logic [1:0] osc_q; // Last oscillator levels
    // Saturates, so a long stop never wraps back to zero
    always_comb begin
        still_d = still_q;
        if ({MAIN_OSC_INPUT, SUB_OSC_INPUT} != osc_q) begin
            still_d = 4'h0;
        end else if (still_q != 4'hf) begin
            still_d = still_q + 4'h1;
        end
    end
    // Register the stillness count
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            still_q <= 4'h0;
            osc_q <= 2'h0;
        end else begin
            still_q <= still_d;
            osc_q <= {MAIN_OSC_INPUT, SUB_OSC_INPUT};
        end
    end
    // Reset check must not be switched off by the reset it watches
    AST_RESET_OUTS: assert property (disable iff (1'b0) !RST_N |=>
        (RDATA == 8'h00 && PORT_DIR == 8'h00 && !PHI && !BUSY)) else $error("outputs not reset");
    AST_READ_IDLE: assert property (!RD |=> RDATA == 8'h00)
        else $error("read data without read");
    AST_DIR_READ_ZERO: assert property (RD && ADDR == cpusf_pkg::REG_DIR |=>
        RDATA == 8'h00) else $error("direction register readable");
    AST_DIR_WRITE: assert property (WR && ADDR == cpusf_pkg::REG_DIR |=>
        PORT_DIR == $past(WDATA)) else $error("direction write lost");
    AST_DIR_HOLD: assert property (!(WR && ADDR == cpusf_pkg::REG_DIR) |=>
        $stable(PORT_DIR)) else $error("direction changed unasked");
    AST_CMD_START: assert property (WR && ADDR == cpusf_pkg::REG_CMD && !BUSY &&
        WDATA >= 8'h01 && WDATA <= 8'h0d |=> BUSY) else $error("command did not start");
    AST_BUSY_MIN: assert property ($rose(BUSY) |-> BUSY[*3])
        else $error("operation too short");
    AST_BUSY_BOUND: assert property ($rose(BUSY) |-> ##[1:700] !BUSY)
        else $error("operation never ends");
    AST_PHI_STILL: assert property (still_q >= 4'h8 |-> $stable(PHI))
        else $error("phi moved without oscillator");
    COV_CMD: cover property ($fell(BUSY));
    COV_DIR: cover property (WR && ADDR == cpusf_pkg::REG_DIR);
    COV_STILL: cover property (still_q == 4'hf);
endmodule

bind cpusf_core cpusf_core_monitor i_mon (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
    .MAIN_OSC_INPUT(MAIN_OSC_INPUT), .SUB_OSC_INPUT(SUB_OSC_INPUT), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .IRQ_REQ(IRQ_REQ), .RDATA(RDATA),
    .PORT_DIR(PORT_DIR), .PHI(PHI), .BUSY(BUSY));

// *** verif/cpusf_tb_top.sv ***
// Testbench for the status flag block, driven through its register port.
// Assumes cpusf_core with its monitor bound; oscillators made here.
`timescale 1ns/1ps
module cpusf_tb_top;
    logic CLK_SYS, RST_N, WR, RD, PHI, BUSY;
    logic MAIN_OSC_INPUT = 1'b0, SUB_OSC_INPUT = 1'b0; // Oscillators start low
    logic [3:0] ADDR;
    logic [3:0] IRQ_REQ;
    logic [7:0] WDATA, RDATA, PORT_DIR;
    int error_cnt = 0; // Mismatches
    int n_compared = 0; // Comparisons made
    int cyc = 0; // Hang guard count
    int dur; // Busy cycles of last command
    logic osc_run = 1'b1; // Oscillators toggle while set
    logic [1:0] osc_div = 2'h0; // Sub oscillator divider
    logic [7:0] v, f0; // Read scratch
    cpusf_core i_dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .MAIN_OSC_INPUT(MAIN_OSC_INPUT),
        .SUB_OSC_INPUT(SUB_OSC_INPUT), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .IRQ_REQ(IRQ_REQ), .RDATA(RDATA), .PORT_DIR(PORT_DIR), .PHI(PHI), .BUSY(BUSY));
    // 125 MHz clock
    initial begin
        CLK_SYS = 1'b0;
        forever #4 CLK_SYS = ~CLK_SYS;
    end
    // Main oscillator at half the clock, sub at an eighth
    always @(posedge CLK_SYS) begin
        if (osc_run) begin
            osc_div <= osc_div + 2'h1;
            MAIN_OSC_INPUT <= ~MAIN_OSC_INPUT;
            if (osc_div == 2'h3) begin
                SUB_OSC_INPUT <= ~SUB_OSC_INPUT;
            end
        end
    end
    // Cut a hang short; full run needs well under this
    always @(posedge CLK_SYS) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            $display("CHECK FAILED %0t hang guard", $time);
            wrap_up();
        end
    end
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic rng(input int got, input int lo, input int hi, input string m);
        n_compared++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s got %0d", $time, m, got);
        end
    endtask
    // One-cycle write, then a quiet cycle so strobes never collide
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK_SYS);
        WR <= 1'b0;
        @(posedge CLK_SYS);
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK_SYS);
        RD <= 1'b0;
        #1 d = RDATA;
        @(posedge CLK_SYS);
    endtask
    // Issue a command and time it until busy falls
    task automatic cmd(input cpusf_pkg::cpusf_cmd_type c);
        dur = 0;
        wr(cpusf_pkg::REG_CMD, {4'h0, c});
        #1;
        chk({7'h00, BUSY}, 8'h01, "busy start");
        while (BUSY !== 1'b0 && dur < 2000) begin
            @(posedge CLK_SYS);
            #1;
            dur++;
        end
        rng(dur, 1, 1999, "busy end");
        @(posedge CLK_SYS);
    endtask
    task automatic t_reset;
        rd(cpusf_pkg::REG_FLAGS, v);
        chk(v & 8'h04, 8'h04, "interrupt disable after reset");
        chk(PORT_DIR, 8'h00, "direction after reset");
        $display("test reset done");
    endtask
    task automatic t_dir;
        rd(cpusf_pkg::REG_FLAGS, f0);
        wr(cpusf_pkg::REG_DIR, 8'ha5);
        rd(cpusf_pkg::REG_DIR, v);
        chk(v, 8'h00, "direction read");
        chk(PORT_DIR, 8'ha5, "direction value");
        rd(4'hf, v);
        chk(v, 8'h00, "unmapped read");
        wr(cpusf_pkg::REG_FLAGS, 8'hff);
        rd(cpusf_pkg::REG_FLAGS, v);
        chk(v, f0, "flags not writable");
        $display("test direction done");
    endtask
    // Bit 1 requested but masked; bit 2 is the highest-priority live source
    task automatic t_trap;
        wr(cpusf_pkg::REG_IRQ, 8'h0c);
        IRQ_REQ <= 4'b1110;
        cmd(cpusf_pkg::CMD_TRAP);
        rd(cpusf_pkg::REG_TRAP_VEC, v);
        chk(v, 8'h03, "trap vector");
        IRQ_REQ <= 4'b0000;
        $display("test trap done");
    endtask
    task automatic t_push;
        rd(cpusf_pkg::REG_FLAGS, f0);
        cmd(cpusf_pkg::CMD_PUSH);
        rd(cpusf_pkg::REG_STACK_RD, v);
        chk(v, f0, "pushed flags");
        cmd(f0[cpusf_pkg::FLAG_C] ? cpusf_pkg::CMD_CARRY_CLEAR : cpusf_pkg::CMD_CARRY_SET);
        cmd(cpusf_pkg::CMD_POP);
        rd(cpusf_pkg::REG_FLAGS, v);
        chk(v, f0, "popped flags");
        $display("test push done");
    endtask
    // Same results and untouched flags with T and D both set or both clear
    task automatic t_md(input logic t, input logic d);
        cmd(t ? cpusf_pkg::CMD_SET_T : cpusf_pkg::CMD_CLR_T);
        cmd(d ? cpusf_pkg::CMD_DEC_SET : cpusf_pkg::CMD_DEC_CLEAR);
        wr(cpusf_pkg::REG_ACC, 8'h12);
        wr(cpusf_pkg::REG_OPER, 8'h34);
        rd(cpusf_pkg::REG_FLAGS, f0);
        cmd(cpusf_pkg::CMD_PRODUCT);
        rd(cpusf_pkg::REG_ACC, v);
        chk(v, 8'ha8, "product low");
        rd(cpusf_pkg::REG_RESULT, v);
        chk(v, 8'h03, "product high");
        wr(cpusf_pkg::REG_ACC, 8'h64);
        wr(cpusf_pkg::REG_OPER, 8'h07);
        cmd(cpusf_pkg::CMD_DIV);
        rd(cpusf_pkg::REG_ACC, v);
        chk(v, 8'h0e, "quotient");
        rd(cpusf_pkg::REG_RESULT, v);
        chk(v, 8'h02, "remainder");
        rd(cpusf_pkg::REG_FLAGS, v);
        chk(v, f0, "flags kept");
        $display("test multiply divide done");
    endtask
    task automatic dec_case(input cpusf_pkg::cpusf_cmd_type op, input logic [7:0] a,
        input logic [7:0] b, input logic ci, input logic [7:0] e, input logic co);
        wr(cpusf_pkg::REG_ACC, a);
        wr(cpusf_pkg::REG_OPER, b);
        cmd(ci ? cpusf_pkg::CMD_CARRY_SET : cpusf_pkg::CMD_CARRY_CLEAR);
        cmd(op);
        rd(cpusf_pkg::REG_ACC, v);
        chk(v, e, "arith result");
        cmd(cpusf_pkg::CMD_CLR_T);
        rd(cpusf_pkg::REG_FLAGS, v);
        chk({7'h00, v[cpusf_pkg::FLAG_C]}, {7'h00, co}, "arith carry");
    endtask
    task automatic t_dec;
        cmd(cpusf_pkg::CMD_CLR_T);
        cmd(cpusf_pkg::CMD_DEC_CLEAR);
        cmd(cpusf_pkg::CMD_DEC_SET);
        dec_case(cpusf_pkg::CMD_ADC, 8'h19, 8'h28, 1'b0, 8'h47, 1'b0);
        dec_case(cpusf_pkg::CMD_ADC, 8'h58, 8'h47, 1'b0, 8'h05, 1'b1);
        dec_case(cpusf_pkg::CMD_SUB_BORROW, 8'h10, 8'h01, 1'b1, 8'h09, 1'b1);
        dec_case(cpusf_pkg::CMD_SUB_BORROW, 8'h00, 8'h01, 1'b1, 8'h99, 1'b0);
        cmd(cpusf_pkg::CMD_DEC_CLEAR);
        dec_case(cpusf_pkg::CMD_ADC, 8'h19, 8'h28, 1'b0, 8'h41, 1'b0);
        dec_case(cpusf_pkg::CMD_SUB_BORROW, 8'h10, 8'h01, 1'b1, 8'h0f, 1'b1);
        $display("test decimal done");
    endtask
    // Phase of phi against a command start is free, hence the slack
    task automatic t_phi;
        int cnt, per, d1;
        logic p;
        for (int m = 0; m < 3; m++) begin
            wr(cpusf_pkg::REG_SPEED, 8'(m));
            repeat (40) @(posedge CLK_SYS);
            cnt = 0;
            p = 1'b1;
            repeat (256) begin
                @(posedge CLK_SYS);
                #1;
                if (PHI === 1'b1 && p === 1'b0) cnt++;
                p = PHI;
            end
            @(posedge CLK_SYS);
            per = (m == 0) ? 2 * cpusf_pkg::DIV_HIGH : (m == 1) ? 2 * cpusf_pkg::DIV_MIDDLE
                : 8 * cpusf_pkg::DIV_LOW;
            rng(cnt, 256 / per - 1, 256 / per + 1, "phi rate");
        end
        wr(cpusf_pkg::REG_SPEED, 8'h00);
        repeat (40) @(posedge CLK_SYS);
        cmd(cpusf_pkg::CMD_ADC);
        d1 = dur;
        cmd(cpusf_pkg::CMD_ADC);
        rng(dur, d1 - 4, d1 + 4, "repeat duration");
        cmd(cpusf_pkg::CMD_PRODUCT);
        per = int'(cpusf_pkg::CYC_PROD - cpusf_pkg::CYC_ALU) * 4;
        rng(dur - d1, per - 4, per + 4, "multiply duration");
        osc_run <= 1'b0;
        repeat (8) @(posedge CLK_SYS);
        #1 p = PHI;
        cnt = 0;
        repeat (20) begin
            @(posedge CLK_SYS);
            #1;
            if (PHI !== p) cnt++;
        end
        rng(cnt, 0, 0, "phi still");
        @(posedge CLK_SYS);
        osc_run <= 1'b1;
        $display("test phi done");
    endtask
    // Main sequence; no jump command is ever issued, so no page-end pointer
    initial begin
        RST_N = 1'b0;
        WR = 1'b0;
        RD = 1'b0;
        ADDR = 4'h0;
        WDATA = 8'h00;
        IRQ_REQ = 4'h0;
        repeat (2) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        @(posedge CLK_SYS);
        t_reset();
        t_dir();
        t_trap();
        t_push();
        t_md(1'b1, 1'b1);
        t_md(1'b0, 1'b0);
        t_dec();
        t_phi();
        wrap_up();
    end
endmodule
